// *** pkg/pcstack_pkg.sv ***
`default_nettype none
package pcstack_pkg;
  // register indexes; the bus byte address is four times the index
  localparam logic [11:0] IDX_SHAD_FLAGS = 12'hfe4;
  localparam logic [11:0] IDX_SHAD_ACC   = 12'hfe5;
  localparam logic [11:0] IDX_SHAD_BANK  = 12'hfe6;
  localparam logic [11:0] IDX_SHAD_LATCH = 12'hfe7;
  localparam logic [11:0] IDX_SHAD_P0L   = 12'hfe8;
  localparam logic [11:0] IDX_SHAD_P0H   = 12'hfe9;
  localparam logic [11:0] IDX_SHAD_P1L   = 12'hfea;
  localparam logic [11:0] IDX_SHAD_P1H   = 12'hfeb;
  localparam logic [11:0] IDX_STACK_IDX  = 12'hfed;
  localparam logic [11:0] IDX_TOP_LOW    = 12'hfee;
  localparam logic [11:0] IDX_TOP_HIGH   = 12'hfef;
  localparam logic [11:0] IDX_CTRL       = 12'hf00;
  localparam logic [11:0] IDX_IRQ_STAT   = 12'hf01;
  localparam logic [11:0] IDX_IRQ_MASK   = 12'hf02;
  localparam logic [11:0] IDX_PC_VIEW    = 12'hf03;

  // ctrl register fields
  localparam int CTRL_FAULT_EN = 0;
  // status / mask fields
  localparam int ST_OVERRUN  = 0;
  localparam int ST_UNDERRUN = 1;
  localparam int ST_FAULT    = 2;
  localparam int ST_W        = 3;

  localparam logic [4:0]  STACK_IDX_RESET = 5'h1f;
  localparam logic [14:0] PC_RESET        = 15'h0000;
  localparam logic [31:0] SLV_ERR_DATA    = 32'h0000_0000;

  typedef enum logic [3:0] {
    op_none,
    op_step,
    op_write_low,
    op_call_lit,
    op_call_acc,
    op_jump_acc,
    op_jump_rel,
    op_goto_lit,
    op_int_entry,
    op_return,
    op_return_lit,
    op_return_int
  } pc_op_t;

  function automatic logic [13:0] word_index(input logic [15:0] addr);
    return addr[15:2];
  endfunction
endpackage
`default_nettype wire

// *** hw/return_stack.sv ***
`timescale 1ns/1ps
`default_nettype none
module return_stack
  import pcstack_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [3:0]       wr_slot,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [3:0]       rd_slot,
  output logic      [WIDTH-1:0] rd_data
);
  // slot ports are four bits wide, so only sixteen entries can be served
  if (DEPTH != 16 || WIDTH < 1)
  begin
    $error("return_stack: DEPTH must be 16");
  end

  // kept apart from program and data storage
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (wr_en)
      mem_q[wr_slot] <= wr_data;
  end

  assign rd_data = mem_q[rd_slot];
endmodule
`default_nettype wire

// *** hw/context_shadow.sv ***
`timescale 1ns/1ps
`default_nettype none
module context_shadow
  import pcstack_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        save,
  input  wire logic [63:0] live_ctx,
  input  wire logic [2:0]  sw_sel,
  input  wire logic        sw_we,
  input  wire logic [7:0]  sw_data,
  output logic      [63:0] shadow_ctx
);
  // eight bytes: flags, acc, bank, latch, p0l, p0h, p1l, p1h
  logic [7:0] shad_q [8];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        shad_q[i] <= 8'h00;
    end
    else if (save)
    begin
      for (int i = 0; i < 8; i++)
        shad_q[i] <= live_ctx[i*8 +: 8];
    end
    else if (sw_we)
      shad_q[sw_sel] <= sw_data;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      shadow_ctx[i*8 +: 8] = shad_q[i];
  end
endmodule
`default_nettype wire

// *** hw/pc_sequencer.sv ***
// Notes on behaviour
// - counter is 15 bits; low byte software visible, upper bits from latch
// - any reset clears the whole counter
// - writing the low byte also loads upper bits from latch
// - literal call: operand gives low byte and upper 2:0; latch gives 6:3
// - computed call: accumulator is low byte, latch is upper bits
// - accumulator jump: counter plus one plus unsigned accumulator
// - relative jump: counter plus one plus sign-extended operand
// - sixteen entry, fifteen bit return stack, separate storage
// - calls and interrupt entry push; all three returns pop
// - push and pop leave the upper latch untouched
// - fault reset off: stack wraps, seventeenth push overwrites first
// - overrun and underrun flags set whether or not fault reset is on
// - top entry window follows stack index, read and write
// - stack index is five bits wide
// - push increments then writes; return reads then decrements
// - fault reset on: over or underflow requests a core reset
`timescale 1ns/1ps
`default_nettype none
module pc_sequencer
  import pcstack_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // decoder side
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_code,
  input  wire logic [10:0] op_operand,
  input  wire logic [7:0]  low_byte_wdata,
  input  wire logic [7:0]  accumulator_reg,
  input  wire logic [7:0]  counter_upper_latch,
  input  wire logic [14:0] interrupt_vector,
  input  wire logic [7:0]  live_flags,
  input  wire logic [7:0]  live_bank,
  input  wire logic [7:0]  live_p0l,
  input  wire logic [7:0]  live_p0h,
  input  wire logic [7:0]  live_p1l,
  input  wire logic [7:0]  live_p1h,
  input  wire logic        stack_fault_reset_en,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core side results
  output logic      [14:0] program_counter,
  output logic             restore_valid,
  output logic      [63:0] restore_ctx,
  output logic             fault_reset_req,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [14:0] pc_q, pc_d;
  logic [4:0]  sidx_q, sidx_d;
  logic [14:0] stk_rd;
  logic        stk_we;
  logic [3:0]  stk_slot;
  logic [14:0] stk_wdata;
  logic [ST_W-1:0] stat_q, mask_q, stat_set;
  logic        fault_en_q;
  logic [63:0] shadow_ctx;
  logic        shad_sw_we;
  logic        restore_q;
  logic        fault_q;
  logic        irq_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        pc_flag_sync1_q, pc_flag_sync2_q;

  pc_op_t op;
  assign op = pc_op_t'(op_code);

  logic apb_setup, apb_wr, apb_rd;
  logic [11:0] idx;
  logic [13:0] widx;
  assign apb_setup = psel && !penable;
  assign widx      = word_index(paddr);
  assign idx       = widx[11:0];
  // the slave answers in the access phase right after setup, zero waits
  assign apb_wr    = psel && penable && pwrite && pready_q;
  assign apb_rd    = apb_setup && !pwrite;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // stack pointer arithmetic and fault detection
  logic        is_push, is_pop, overflow, underflow;
  logic [4:0]  push_idx;
  assign is_push   = op_valid && (op == op_call_lit || op == op_call_acc
                                  || op == op_int_entry);
  assign is_pop    = op_valid && (op == op_return || op == op_return_lit
                                  || op == op_return_int);
  assign push_idx  = sidx_q + 5'd1;
  // index 15 is the last real slot; 31 means empty
  assign overflow  = is_push && (sidx_q == 5'h0f);
  assign underflow = is_pop && (sidx_q == 5'h1f);

  always_comb
  begin
    sidx_d = sidx_q;
    if (is_push)
      sidx_d = (overflow && !fault_en_q) ? 5'h00 : push_idx;
    else if (is_pop)
      sidx_d = sidx_q - 5'd1;
    if (!op_valid || !(is_push || is_pop))
      if (apb_wr && addr_hit(idx, IDX_STACK_IDX))
        sidx_d = pwdata[4:0];
  end

  // stack storage write: push, or software writing the top window
  always_comb
  begin
    stk_we    = 1'b0;
    stk_slot  = sidx_q[3:0];
    stk_wdata = stk_rd;
    if (is_push)
    begin
      stk_we    = 1'b1;
      stk_slot  = sidx_d[3:0];
      stk_wdata = pc_q;
    end
    else if (apb_wr && addr_hit(idx, IDX_TOP_LOW))
    begin
      stk_we    = 1'b1;
      stk_wdata = {stk_rd[14:8], pwdata[7:0]};
    end
    else if (apb_wr && addr_hit(idx, IDX_TOP_HIGH))
    begin
      stk_we    = 1'b1;
      stk_wdata = {pwdata[6:0], stk_rd[7:0]};
    end
  end

  return_stack #(.DEPTH(16), .WIDTH(15)) u_stack
  (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (stk_we),
    .wr_slot (stk_slot),
    .wr_data (stk_wdata),
    .rd_slot (sidx_q[3:0]),
    .rd_data (stk_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // next program counter; the latch is only read here, never written
  always_comb
  begin
    pc_d = pc_q;
    if (op_valid)
    begin
      unique case (op)
        op_step:       pc_d = pc_q + 15'd1;
        op_write_low:  pc_d = {counter_upper_latch[6:0], low_byte_wdata};
        op_call_lit:   pc_d = {counter_upper_latch[6:3], op_operand};
        op_goto_lit:   pc_d = {counter_upper_latch[6:3], op_operand};
        op_call_acc:   pc_d = {counter_upper_latch[6:0], accumulator_reg};
        op_jump_acc:   pc_d = pc_q + 15'd1 + {7'h00, accumulator_reg};
        op_jump_rel:   pc_d = pc_q + 15'd1
                              + {{4{op_operand[10]}}, op_operand};
        op_int_entry:  pc_d = interrupt_vector;
        op_return,
        op_return_lit,
        op_return_int: pc_d = stk_rd;
        default:       pc_d = pc_q;
      endcase
    end
    else if (apb_wr && addr_hit(idx, IDX_PC_VIEW))
      pc_d = {counter_upper_latch[6:0], pwdata[7:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_q <= PC_RESET;
    else if (fault_q)
      pc_q <= PC_RESET;
    else
      pc_q <= pc_d;
  end

  // the fault reset returns the index to empty like any other reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sidx_q <= STACK_IDX_RESET;
    else if (fault_q)
      sidx_q <= STACK_IDX_RESET;
    else
      sidx_q <= sidx_d;
  end

  // configuration strap comes from outside the core clock domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_flag_sync1_q <= 1'b0;
      pc_flag_sync2_q <= 1'b0;
    end
    else
    begin
      pc_flag_sync1_q <= stack_fault_reset_en;
      pc_flag_sync2_q <= pc_flag_sync1_q;
    end
  end

  // software may also enable it in the ctrl register
  logic ctrl_en_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_en_q <= 1'b0;
    else if (apb_wr && addr_hit(idx, IDX_CTRL))
      ctrl_en_q <= pwdata[CTRL_FAULT_EN];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_en_q <= 1'b0;
    else
      fault_en_q <= pc_flag_sync2_q || ctrl_en_q;
  end

  // one-cycle reset request; the core is expected to reset on it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_q <= 1'b0;
    else
      fault_q <= fault_en_q && (overflow || underflow);
  end

  ////////////////////////////////////////////////////////////////////////
  // context shadows
  assign shad_sw_we = apb_wr && (idx >= IDX_SHAD_FLAGS) && (idx <= IDX_SHAD_P1H);

  context_shadow u_shadow
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .save       (op_valid && op == op_int_entry),
    .live_ctx   ({live_p1h, live_p1l, live_p0h, live_p0l,
                  counter_upper_latch, live_bank, accumulator_reg, live_flags}),
    .sw_sel     (3'(idx - IDX_SHAD_FLAGS)),
    .sw_we      (shad_sw_we),
    .sw_data    (pwdata[7:0]),
    .shadow_ctx (shadow_ctx)
  );

  // restore strobe is seen by the core one cycle after the return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      restore_q <= 1'b0;
    else
      restore_q <= op_valid && (op == op_return_int);
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear; a new event wins over the clear
  assign stat_set = {fault_q, underflow, overflow};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= '0;
    else if (apb_wr && addr_hit(idx, IDX_IRQ_STAT))
      stat_q <= (stat_q & ~pwdata[ST_W-1:0]) | stat_set;
    else
      stat_q <= stat_q | stat_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= '0;
    else if (apb_wr && addr_hit(idx, IDX_IRQ_MASK))
      mask_q <= pwdata[ST_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_d_view() & mask_q);
  end

  function automatic logic [ST_W-1:0] stat_d_view();
    return stat_q;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb read path, captured in setup so data stand through the access phase
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = SLV_ERR_DATA;
    if (addr_hit(idx, IDX_STACK_IDX))       rd_mux = {27'h0, sidx_q};
    else if (addr_hit(idx, IDX_TOP_LOW))    rd_mux = {24'h0, stk_rd[7:0]};
    else if (addr_hit(idx, IDX_TOP_HIGH))   rd_mux = {25'h0, stk_rd[14:8]};
    else if (addr_hit(idx, IDX_CTRL))       rd_mux = {31'h0, ctrl_en_q};
    else if (addr_hit(idx, IDX_IRQ_STAT))   rd_mux = {29'h0, stat_q};
    else if (addr_hit(idx, IDX_IRQ_MASK))   rd_mux = {29'h0, mask_q};
    else if (addr_hit(idx, IDX_PC_VIEW))    rd_mux = {24'h0, pc_q[7:0]};
    else if (idx >= IDX_SHAD_FLAGS && idx <= IDX_SHAD_P1H)
      rd_mux = {24'h0, shadow_ctx[8*(3'(idx - IDX_SHAD_FLAGS)) +: 8]};
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup && !rd_hit;
      if (apb_rd)
        prdata_q <= rd_mux;
      else if (apb_setup)
        prdata_q <= 32'h0000_0000;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign program_counter = pc_q;
  assign restore_valid   = restore_q;
  assign restore_ctx     = shadow_ctx;
  assign fault_reset_req = fault_q;
  assign irq             = irq_q;
endmodule
`default_nettype wire

// *** dv/pc_sequencer_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pc_sequencer_props
  import pcstack_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        op_valid,
  input wire logic [3:0]  op_code,
  input wire logic [10:0] op_operand,
  input wire logic [7:0]  low_byte_wdata,
  input wire logic [7:0]  accumulator_reg,
  input wire logic [7:0]  counter_upper_latch,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [14:0] program_counter,
  input wire logic        restore_valid,
  input wire logic        fault_reset_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  low_write_a:
    assert property (op_valid && op_code == op_write_low |=>
      program_counter[7:0] == $past(low_byte_wdata) &&
      program_counter[14:8] == 7'($past(counter_upper_latch)))
    else $error("low byte load wrong");
  lit_call_a:
    assert property (op_valid && op_code == op_call_lit |=>
      program_counter[10:0] == $past(op_operand) &&
      program_counter[14:11] == 4'($past(counter_upper_latch) >> 3))
    else $error("literal call target wrong");
  acc_call_a:
    assert property (op_valid && op_code == op_call_acc |=>
      program_counter == 15'({$past(counter_upper_latch), $past(accumulator_reg)}))
    else $error("computed call target wrong");
  acc_jump_a:
    assert property (op_valid && op_code == op_jump_acc |=> program_counter ==
      15'($past(program_counter) + 15'h1 + $past(accumulator_reg)))
    else $error("accumulator jump target wrong");
  rel_jump_a:
    assert property (op_valid && op_code == op_jump_rel |=> program_counter ==
      15'($past(program_counter) + 15'h1 + 15'(signed'($past(op_operand)))))
    else $error("relative jump target wrong");
  restore_pulse_a:
    assert property (op_valid && op_code == op_return_int |=> restore_valid ##1 !restore_valid)
    else $error("restore pulse wrong");
  fault_clear_a:
    assert property (fault_reset_req |=> program_counter == 15'h0)
    else $error("fault reset left counter set");
  apb_ready_a:
    assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  bad_addr_a:
    assert property (psel && penable && pready && paddr == 16'h0000 |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind pc_sequencer pc_sequencer_props chk (
  .pclk,
  .presetn,
  .op_valid,
  .op_code,
  .op_operand,
  .low_byte_wdata,
  .accumulator_reg,
  .counter_upper_latch,
  .psel,
  .penable,
  .paddr,
  .pready,
  .pslverr,
  .program_counter,
  .restore_valid,
  .fault_reset_req
);
`default_nettype wire

// *** dv/core_decoder_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_decoder_model
  import pcstack_pkg::*;
(
  input  wire logic        pclk,
  output var logic         op_valid,
  output wire logic [3:0]  op_code,
  output wire logic [10:0] op_operand
);
  logic [3:0]  c_q = 4'h0;
  logic [10:0] a_q = 11'h0;
  logic [14:0] j_q = 15'h1234;
  initial
    op_valid = 1'b0;
  // idle fields keep toggling so a stale operand is never taken for a live one
  always @(posedge pclk)
    j_q <= ~j_q;
  assign op_code = op_valid ? c_q : j_q[3:0];
  assign op_operand = op_valid ? a_q : j_q[14:4];
  //////////////////////////////////////////////////////////////////////////
  task automatic issue(input pc_op_t c, input logic [10:0] a, input int gap);
    repeat (gap) @(posedge pclk);
    op_valid <= 1'b1;
    c_q <= c;
    a_q <= a;
    @(posedge pclk);
    op_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/program_counter_and_call_stack_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module program_counter_and_call_stack_bench
  import pcstack_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, strap = 1'b0, op_seen = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        op_valid, pready, pslverr, restore_valid, fault_reset_req, irq;
  logic [3:0]  op_code;
  logic [10:0] op_operand;
  logic [7:0]  wd = 8'h0, acc = 8'h0, latch = 8'h0, flags = 8'h0, bank = 8'h0;
  logic [7:0]  p0l = 8'h0, p0h = 8'h0, p1l = 8'h0, p1h = 8'h0;
  logic [14:0] ivec = 15'h0, program_counter, pc = 15'h0, stk [16];
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, lf = 32'ha99d;
  logic [63:0] restore_ctx, sh = 64'h0, expq [$];
  logic [4:0]  idx = 5'h1f;
  logic [2:0]  st = 3'h0;
  int          n_fail = 0, total_checks = 0;
  always #4 pclk = ~pclk;
  core_decoder_model dec (
    .pclk,
    .op_valid,
    .op_code,
    .op_operand
  );
  pc_sequencer dut (
    .pclk,
    .presetn,
    .op_valid,
    .op_code,
    .op_operand,
    .low_byte_wdata       (wd),
    .accumulator_reg      (acc),
    .counter_upper_latch  (latch),
    .interrupt_vector     (ivec),
    .live_flags           (flags),
    .live_bank            (bank),
    .live_p0l             (p0l),
    .live_p0h             (p0h),
    .live_p1l             (p1l),
    .live_p1h             (p1h),
    .stack_fault_reset_en (strap),
    .psel,
    .penable,
    .pwrite,
    .paddr,
    .pwdata,
    .prdata,
    .pready,
    .pslverr,
    .program_counter,
    .restore_valid,
    .restore_ctx,
    .fault_reset_req,
    .irq
  );
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic take(input logic [63:0] got);
    logic [63:0] e;
    e = ~got;
    if (expq.size() > 0)
      e = expq.pop_front();
    `CHK(got, e)
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never flips psel within one step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    expq.push_back({32'h0, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(negedge pclk);
    `CHK(irq, e)
    @(posedge pclk);
  endtask
  task automatic op(input pc_op_t c, input logic [10:0] a);
    logic [14:0] nx;
    lf = nxt(lf);
    acc <= lf[7:0];
    wd <= lf[15:8];
    latch <= {1'b0, lf[22:16]};
    ivec <= lf[31:17];
    flags <= {5'h0, lf[26:24]};
    bank <= {3'h0, lf[20:16]};
    lf = nxt(lf);
    {p1h, p1l, p0h, p0l} <= lf;
    @(posedge pclk);
    case (c)
      op_step: nx = pc + 15'h1;
      op_goto_lit: nx = {latch[6:3], a};
      op_write_low: nx = {latch[6:0], wd};
      op_call_lit: nx = {latch[6:3], a};
      op_call_acc: nx = {latch[6:0], acc};
      op_jump_acc: nx = pc + 15'h1 + {7'h0, acc};
      op_jump_rel: nx = pc + 15'h1 + {{4{a[10]}}, a};
      op_int_entry: nx = ivec;
      default: nx = stk[idx[3:0]];
    endcase
    if (c inside {op_call_lit, op_call_acc, op_int_entry})
    begin
      st[0] |= (idx == 5'h0f);
      idx = (idx == 5'h0f) ? 5'h00 : idx + 5'h01;
      stk[idx[3:0]] = pc;
    end
    else if (c >= op_return)
    begin
      st[1] |= (idx == 5'h1f);
      idx = idx - 5'h01;
    end
    if (c == op_int_entry)
      sh = {p1h, p1l, p0h, p0l, latch, bank, acc, flags};
    pc = nx;
    expq.push_back({49'h0, nx});
    if (c == op_return_int)
      expq.push_back(sh);
    dec.issue(c, a, int'(lf[0]));
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
    op_seen <= op_valid;
  always @(negedge pclk)
  begin
    if (op_seen)
      take({49'h0, program_counter});
    if (restore_valid)
      take(restore_ctx);
    if (psel && penable && pready && !pwrite)
      take({32'h0, prdata});
  end
  initial
  begin
    #200000;
    n_fail++;
    results();
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(16'h3fb4, 32'h1f);
    rd(16'h3c0c, 32'h0);
    rd(16'h0000, 32'h0);
    op(op_write_low, 11'h0);
    apb(1'b1, 16'h3c0c, 32'h5b);
    pc = {latch[6:0], 8'h5b};
    rd(16'h3c0c, 32'h5b);
    op(op_jump_rel, 11'h7f0);
    op(op_call_lit, 11'h5a3);
    op(op_call_acc, 11'h0);
    op(op_jump_acc, 11'h0);
    op(op_step, 11'h0);
    op(op_goto_lit, 11'h2c5);
    op(op_int_entry, 11'h0);
    rd(16'h3f94, {24'h0, sh[15:8]});
    rd(16'h3fb4, {27'h0, idx});
    rd(16'h3fb8, {24'h0, stk[idx[3:0]][7:0]});
    rd(16'h3fbc, {25'h0, stk[idx[3:0]][14:8]});
    op(op_return_int, 11'h0);
    op(op_return_lit, 11'h0);
    op(op_return, 11'h0);
    apb(1'b1, 16'h3fb4, 32'h0);
    apb(1'b1, 16'h3fb8, 32'h34);
    apb(1'b1, 16'h3fbc, 32'h12);
    idx = 5'h00;
    stk[0] = 15'h1234;
    op(op_return, 11'h0);
    for (int i = 0; i < 17; i++)
      op(op_call_lit, 11'(i * 97));
    rd(16'h3fb4, 32'h0);
    rd(16'h3fb8, {24'h0, stk[0][7:0]});
    irq_is(1'b0);
    apb(1'b1, 16'h3c08, 32'h7);
    irq_is(1'b1);
    rd(16'h3c04, {29'h0, st});
    apb(1'b1, 16'h3c04, 32'h1);
    st[0] = 1'b0;
    irq_is(1'b0);
    apb(1'b1, 16'h3fb4, 32'h1f);
    idx = 5'h1f;
    op(op_return, 11'h0);
    irq_is(1'b1);
    rd(16'h3c04, {29'h0, st});
    apb(1'b1, 16'h3c04, 32'h2);
    st[1] = 1'b0;
    irq_is(1'b0);
    // fault reset through the control bit, then through the strap
    apb(1'b1, 16'h3c00, 32'h1);
    apb(1'b1, 16'h3fb4, 32'h0f);
    idx = 5'h0f;
    op(op_call_acc, 11'h0);
    repeat (4) @(posedge pclk);
    pc = 15'h0;
    idx = 5'h1f;
    st[2] = 1'b1;
    rd(16'h3fb4, 32'h1f);
    rd(16'h3c0c, 32'h0);
    apb(1'b1, 16'h3c00, 32'h0);
    strap <= 1'b1;
    repeat (4) @(posedge pclk);
    op(op_return, 11'h0);
    repeat (4) @(posedge pclk);
    pc = 15'h0;
    idx = 5'h1f;
    rd(16'h3c04, {29'h0, st});
    rd(16'h3fb4, 32'h1f);
    results();
  end
endmodule
`default_nettype wire
